// ===== src/upp_host_port.sv
// UART-style parallel host port: host bus decode and register file
// How it works
// RULE_01: Three address lines pick the target register on each host access.
// RULE_02: Divisor access bit changes what addresses zero and one reach.
// RULE_03: Eight data lines with tri-state drive carry data, control and status.
// RULE_04: Bit clear: address 0 is receive/transmit data, 1 is interrupt enable.
// RULE_05: Bit set: addresses 0 and 1 reach divisor low and high bytes.
// RULE_06: Interrupt identification ignores the bit and cannot be written.
// RULE_07: Line status ignores the bit and is read-only.
// RULE_08: Strobes count only while chip select is low.
// RULE_09: Select and read low drive the addressed register onto the bus.
// RULE_10: Reads give status or data; reading the receive buffer consumes it.
// RULE_11: Select and write low load the bus byte into the register.
// RULE_12: Driver disable is low only during a selected read.
// RULE_13: Interrupt output shows pending status, gated by aux output B.
// RULE_14: Line control 3, modem control 4, status 5 and 6, scratch 7.
module upp_host_port (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire upp_pkg::upp_addr_t host_addr_lines,
  input wire upp_pkg::upp_byte_t host_data_in,
  output upp_pkg::upp_byte_t host_data_out,
  output logic host_data_oe,
  input wire logic host_select_n,
  input wire logic host_read_n,
  input wire logic host_write_n,
  output logic bus_driver_disable,
  output logic host_irq,
  input wire upp_pkg::upp_byte_t rx_byte,
  input wire logic rx_byte_valid,
  input wire logic [2:0] rx_error,
  output upp_pkg::upp_byte_t tx_byte,
  output logic tx_byte_valid,
  input wire logic tx_byte_taken,
  input wire logic tx_idle,
  input wire logic [3:0] modem_lines,
  output upp_pkg::upp_byte_t line_control,
  output upp_pkg::upp_byte_t modem_control,
  output logic [15:0] baud_divisor
);
  import upp_pkg::*;

  logic rd_act_ff;
  logic wr_act_ff;
  upp_byte_t rbr_ff;
  upp_byte_t thr_ff;
  upp_byte_t ier_ff;
  upp_byte_t lcr_ff;
  upp_byte_t mcr_ff;
  upp_byte_t scr_ff;
  upp_byte_t dll_ff;
  upp_byte_t dlm_ff;
  logic dr_ff;
  logic [3:0] lerr_ff;
  logic thr_full_ff;
  logic thre_irq_ff;
  logic [3:0] msr_d_ff;
  logic [3:0] lines_ff;
  upp_byte_t dout_ff;
  logic oe_ff;
  logic dis_ff;
  logic irq_ff;
  logic txv_ff;

  // Strobes are qualified by chip select
  wire rd_act = !host_select_n && !host_read_n; // RULE_08 RULE_09
  wire wr_act = !host_select_n && !host_write_n; // RULE_08 RULE_11
  // Side effects fire once per access, on its first cycle
  wire rd_start = rd_act && !rd_act_ff;
  wire wr_start = wr_act && !wr_act_ff;

  wire divisor_access_bit = lcr_ff[UPP_LCR_DIV_ACCESS];
  wire [2:0] a = host_addr_lines; // RULE_01

  wire sel_data = (a == UPP_A_DATA) && !divisor_access_bit; // RULE_02 RULE_04
  wire sel_ier = (a == UPP_A_IER) && !divisor_access_bit; // RULE_04
  wire sel_dll = (a == UPP_A_DIV_LO) && divisor_access_bit; // RULE_05
  wire sel_dlm = (a == UPP_A_DIV_HI) && divisor_access_bit; // RULE_05
  wire sel_iir = (a == UPP_A_IIR); // RULE_06
  wire sel_lcr = (a == UPP_A_LCR); // RULE_14
  wire sel_mcr = (a == UPP_A_MCR); // RULE_14
  wire sel_lsr = (a == UPP_A_LSR); // RULE_07
  wire sel_msr = (a == UPP_A_MSR); // RULE_14
  wire sel_scr = (a == UPP_A_SCR); // RULE_14

  // IIR and LSR have no write enable at all
  wire we_thr = wr_start && sel_data; // RULE_11
  wire we_ier = wr_start && sel_ier;
  wire we_lcr = wr_start && sel_lcr;
  wire we_mcr = wr_start && sel_mcr;
  wire we_scr = wr_start && sel_scr;
  wire we_dll = wr_start && sel_dll;
  wire we_dlm = wr_start && sel_dlm;

  wire rd_rbr = rd_start && sel_data; // RULE_10
  wire rd_iir = rd_start && sel_iir;
  wire rd_lsr = rd_start && sel_lsr;
  wire rd_msr = rd_start && sel_msr;

  // Line status word
  wire thre = !thr_full_ff;
  wire [7:0] lsr = {1'b0, thre && tx_idle, thre, lerr_ff, dr_ff};
  wire [7:0] msr = {lines_ff, msr_d_ff};

  // Interrupt sources after enable masking
  wire src_line = ier_ff[UPP_IER_LINE] && (|lerr_ff);
  wire src_rx = ier_ff[UPP_IER_RX_DATA] && dr_ff;
  wire src_tx = ier_ff[UPP_IER_TX_EMPTY] && thre_irq_ff;
  wire src_modem = ier_ff[UPP_IER_MODEM] && (|msr_d_ff);
  wire [3:0] iir_code = src_line ? UPP_IIR_LINE :
                        src_rx ? UPP_IIR_RX :
                        src_tx ? UPP_IIR_TX :
                        src_modem ? UPP_IIR_MODEM : UPP_IIR_NONE;
  wire [7:0] iir = {4'h0, iir_code};
  wire irq_pend = !iir_code[0];

  // Read mux; high nibble of IER reads zero
  wire [7:0] rd_mux = sel_data ? rbr_ff : // RULE_04 RULE_10
                      sel_ier ? {4'h0, ier_ff[3:0]} :
                      sel_dll ? dll_ff : // RULE_05
                      sel_dlm ? dlm_ff :
                      sel_iir ? iir : // RULE_06
                      sel_lcr ? lcr_ff :
                      sel_mcr ? mcr_ff :
                      sel_lsr ? lsr : // RULE_07
                      sel_msr ? msr : scr_ff;

  // Clearing IIR on read only drops the transmit-empty source
  wire tx_irq_clr = we_thr || (rd_iir && (iir_code == UPP_IIR_TX));

  // Modem line change detection; ring reports its trailing edge
  wire [3:0] line_delta = {1'b0, 3'h0} | {
    lines_ff[3] ^ modem_lines[3],
    lines_ff[2] && !modem_lines[2],
    lines_ff[1] ^ modem_lines[1],
    lines_ff[0] ^ modem_lines[0]};

  wire [3:0] nxt_lerr = (rd_lsr ? 4'h0 : lerr_ff) |
    (rx_byte_valid ? {rx_error[2:0], dr_ff && !rd_rbr} : 4'h0);
  wire [3:0] nxt_msr_d = (rd_msr ? 4'h0 : msr_d_ff) | line_delta;

  // Bus handshake state and the pin-facing flip-flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_act_ff <= 1'b0;
      wr_act_ff <= 1'b0;
      dout_ff <= UPP_RST_DATA;
      oe_ff <= 1'b0;
      dis_ff <= 1'b1;
      irq_ff <= 1'b0;
    end else begin
      rd_act_ff <= rd_act;
      wr_act_ff <= wr_act;
      // Value caught at read start stays put for the whole strobe
      if (rd_start) begin
        dout_ff <= rd_mux; // RULE_09 RULE_10
      end
      oe_ff <= rd_act; // RULE_03 RULE_09
      // Inputs are sampled, so the disable trails the strobe by one cycle at both ends
      dis_ff <= !rd_act; // RULE_12
      irq_ff <= irq_pend && mcr_ff[UPP_MCR_AUX_OUT_B]; // RULE_13
    end
  end

  // Host-writable registers; unused bits are held at zero
  wire [7:0] nxt_ier = we_ier ? {4'h0, host_data_in[3:0]} : ier_ff;
  wire [7:0] nxt_lcr = we_lcr ? host_data_in : lcr_ff; // RULE_11
  wire [7:0] nxt_mcr = we_mcr ? {3'h0, host_data_in[4:0]} : mcr_ff;
  wire [7:0] nxt_scr = we_scr ? host_data_in : scr_ff;
  wire [7:0] nxt_dll = we_dll ? host_data_in : dll_ff; // RULE_05
  wire [7:0] nxt_dlm = we_dlm ? host_data_in : dlm_ff; // RULE_05
  wire [7:0] nxt_thr = we_thr ? host_data_in : thr_ff; // RULE_04
  // Receive side: a new byte sets data ready, beating a same-cycle read
  wire [7:0] nxt_rbr = rx_byte_valid ? rx_byte : rbr_ff;
  wire nxt_dr = rx_byte_valid || (dr_ff && !rd_rbr); // RULE_10
  // Transmit side: a fresh write keeps the register full over a same-cycle take
  wire nxt_thr_full = we_thr || (thr_full_ff && !tx_byte_taken);
  // Emptying event wins over the IIR-read clear but not over a same-cycle THR write
  wire nxt_thre_irq = (thr_full_ff && tx_byte_taken && !we_thr) ||
                      (thre_irq_ff && !tx_irq_clr);

  // One short process per flop keeps each reset value beside its register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ier_ff <= UPP_RST_REG;
    end else begin
      ier_ff <= nxt_ier;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lcr_ff <= UPP_RST_REG;
    end else begin
      lcr_ff <= nxt_lcr; // RULE_11
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mcr_ff <= UPP_RST_REG;
    end else begin
      mcr_ff <= nxt_mcr;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scr_ff <= UPP_RST_REG;
    end else begin
      scr_ff <= nxt_scr;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dll_ff <= UPP_RST_REG;
    end else begin
      dll_ff <= nxt_dll; // RULE_05
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dlm_ff <= UPP_RST_REG;
    end else begin
      dlm_ff <= nxt_dlm; // RULE_05
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      thr_ff <= UPP_RST_REG;
    end else begin
      thr_ff <= nxt_thr; // RULE_04
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rbr_ff <= UPP_RST_DATA;
    end else begin
      rbr_ff <= nxt_rbr;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dr_ff <= 1'b0;
    end else begin
      dr_ff <= nxt_dr; // RULE_10
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lerr_ff <= 4'h0;
    end else begin
      lerr_ff <= nxt_lerr; // RULE_07
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txv_ff <= 1'b0;
    end else begin
      txv_ff <= we_thr;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      thr_full_ff <= 1'b0;
    end else begin
      thr_full_ff <= nxt_thr_full;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      thre_irq_ff <= 1'b1;
    end else begin
      thre_irq_ff <= nxt_thre_irq;
    end
  end

  // Modem status lines and their change flags
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lines_ff <= 4'h0;
      msr_d_ff <= 4'h0;
    end else begin
      lines_ff <= modem_lines;
      msr_d_ff <= nxt_msr_d;
    end
  end

  assign host_data_out = dout_ff;
  assign host_data_oe = oe_ff;
  assign bus_driver_disable = dis_ff;
  assign host_irq = irq_ff;
  assign tx_byte = thr_ff;
  assign tx_byte_valid = txv_ff;
  assign line_control = lcr_ff;
  assign modem_control = mcr_ff;
  assign baud_divisor = {dlm_ff, dll_ff};
endmodule // upp_host_port

// ===== src/upp_pkg.sv
// Constants and types shared by the UART-style parallel host port
package upp_pkg;
  typedef logic [2:0] upp_addr_t;
  typedef logic [7:0] upp_byte_t;

  // Register addresses; DATA and IER double as divisor bytes
  localparam upp_addr_t UPP_A_DATA = 3'h0;
  localparam upp_addr_t UPP_A_IER = 3'h1;
  localparam upp_addr_t UPP_A_IIR = 3'h2;
  localparam upp_addr_t UPP_A_LCR = 3'h3;
  localparam upp_addr_t UPP_A_MCR = 3'h4;
  localparam upp_addr_t UPP_A_LSR = 3'h5;
  localparam upp_addr_t UPP_A_MSR = 3'h6;
  localparam upp_addr_t UPP_A_SCR = 3'h7;
  localparam upp_addr_t UPP_A_DIV_LO = 3'h0;
  localparam upp_addr_t UPP_A_DIV_HI = 3'h1;

  // Field positions
  localparam int UPP_LCR_DIV_ACCESS = 7;
  localparam int UPP_MCR_AUX_OUT_B = 3;
  localparam int UPP_IER_RX_DATA = 0;
  localparam int UPP_IER_TX_EMPTY = 1;
  localparam int UPP_IER_LINE = 2;
  localparam int UPP_IER_MODEM = 3;
  localparam int UPP_LSR_DR = 0;
  localparam int UPP_LSR_OE = 1;
  localparam int UPP_LSR_PE = 2;
  localparam int UPP_LSR_FE = 3;
  localparam int UPP_LSR_BI = 4;
  localparam int UPP_LSR_THRE = 5;
  localparam int UPP_LSR_TEMT = 6;

  // Interrupt identification codes, highest priority first
  localparam logic [3:0] UPP_IIR_LINE = 4'h6;
  localparam logic [3:0] UPP_IIR_RX = 4'h4;
  localparam logic [3:0] UPP_IIR_TX = 4'h2;
  localparam logic [3:0] UPP_IIR_MODEM = 4'h0;
  localparam logic [3:0] UPP_IIR_NONE = 4'h1;

  // Values after reset
  localparam upp_byte_t UPP_RST_REG = 8'h00;
  localparam upp_byte_t UPP_RST_DATA = 8'h00;
endpackage

// ===== testbench/tb_upp_host_port.sv
// Self-checking bench for the parallel host port
module tb_upp_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  import upp_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rx_byte_valid = 1'b0;
  logic tx_byte_taken = 1'b0;
  logic tx_idle = 1'b1;
  logic [2:0] rx_error = 3'h0;
  logic [3:0] modem_lines = 4'h0;
  upp_byte_t rx_byte = 8'h00;
  upp_addr_t host_addr_lines;
  upp_byte_t host_data_in, host_data_out, host_data_drv, tx_byte, line_control, q, r;
  upp_byte_t modem_control;
  logic host_data_oe, host_select_n, host_read_n, host_write_n, bus_driver_disable;
  logic host_irq, tx_byte_valid;
  logic [15:0] baud_divisor;
  int miscompares = 0;
  int checks_done = 0;
  bit ok;
  int rxq[$];
  int exp_r [8] = '{0, 0, 1, 0, 0, 'h60, 0, 0};
  int ra [4] = '{1, 3, 4, 7};
  int mk [4] = '{'h0f, 'h7f, 'h1f, 'hff};
  always #12.5 sys_clk = ~sys_clk;
  assign host_data_in = host_data_oe ? host_data_out : host_data_drv;
  upp_host_port upp_host_port_i (.sys_clk, .reset_n, .host_addr_lines, .host_data_in,
    .host_data_out, .host_data_oe, .host_select_n, .host_read_n, .host_write_n,
    .bus_driver_disable, .host_irq, .rx_byte, .rx_byte_valid, .rx_error, .tx_byte,
    .tx_byte_valid, .tx_byte_taken, .tx_idle, .modem_lines, .line_control,
    .modem_control, .baud_divisor);
  upp_host_model upp_host_model_i (.sys_clk, .host_data_oe, .host_data_out,
    .host_addr_lines, .host_data_drv, .host_select_n, .host_read_n, .host_write_n);
  task automatic chk(input string n, input int e, input logic [15:0] got);
    checks_done++;
    if (got !== e[15:0]) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e[15:0], got);
    end
  endtask
  task automatic rd(input int a, input int e);
    upp_host_model_i.acc(1'b1, 1'b0, a[2:0], 8'h00, q, ok);
    chk("read data", e, {8'h00, q});
    // A read that never answered has been counted above and ends the run
    if (!ok) begin
      end_sim;
    end
  endtask
  task automatic wr(input int a, input int d);
    upp_host_model_i.acc(1'b1, 1'b1, a[2:0], d[7:0], q, ok);
  endtask
  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    r = 8'($urandom(26426));
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    wr(UPP_A_IIR, r);
    wr(UPP_A_LSR, ~r);
    for (int a = 0; a < 8; a++) rd(a, exp_r[a]);
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      wr(ra[i], i == 1 ? r & 8'h7f : r);
      exp_r[ra[i]] = r & mk[i];
      rd(ra[i], exp_r[ra[i]]);
    end
    chk("lcr port", exp_r[3], line_control);
    chk("mcr port", exp_r[4], modem_control);
    wr(UPP_A_LCR, 'h80);
    r = 8'($urandom);
    wr(UPP_A_DIV_LO, r);
    wr(UPP_A_DIV_HI, ~r);
    rd(UPP_A_DIV_LO, r);
    chk("divisor", {~r, r}, baud_divisor);
    wr(UPP_A_LCR, 0);
    rd(UPP_A_IER, exp_r[1]);
    wr(UPP_A_DATA, r);
    chk("tx byte", r, tx_byte);
    rd(UPP_A_LSR, 0);
    @(negedge sys_clk);
    tx_byte_taken = 1'b1;
    @(negedge sys_clk);
    tx_byte_taken = 1'b0;
    rd(UPP_A_LSR, 'h60);
    wr(UPP_A_IER, 1);
    wr(UPP_A_MCR, 'h08);
    r = 8'($urandom);
    @(negedge sys_clk);
    rx_byte = r;
    rxq.push_back(r);
    rx_error = 3'h1;
    rx_byte_valid = 1'b1;
    @(negedge sys_clk);
    rx_byte_valid = 1'b0;
    @(negedge sys_clk);
    chk("irq", 1, host_irq);
    wr(UPP_A_MCR, 0);
    @(negedge sys_clk);
    chk("irq gated", 0, host_irq);
    rd(UPP_A_IIR, 'h04);
    rd(UPP_A_LSR, 'h65);
    rd(UPP_A_DATA, rxq.pop_front());
    rd(UPP_A_LSR, 'h60);
    r = 8'($urandom);
    @(negedge sys_clk);
    modem_lines = r[3:0];
    rd(UPP_A_MSR, {r[3:0], r[3], 1'b0, r[1:0]});
    rd(UPP_A_MSR, {r[3:0], 4'h0});
    upp_host_model_i.acc(1'b0, 1'b1, UPP_A_SCR, 8'(~exp_r[7]), q, ok);
    upp_host_model_i.acc(1'b0, 1'b0, UPP_A_SCR, 8'h00, q, ok);
    rd(UPP_A_SCR, exp_r[7]);
    end_sim;
  end
endmodule // tb_upp_host_port

// ===== testbench/upp_host_model.sv
// Host processor model running single bus cycles on the port
module upp_host_model (
  input wire logic sys_clk,
  input wire logic host_data_oe,
  input wire upp_pkg::upp_byte_t host_data_out,
  output upp_pkg::upp_addr_t host_addr_lines,
  output upp_pkg::upp_byte_t host_data_drv,
  output logic host_select_n,
  output logic host_read_n,
  output logic host_write_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import upp_pkg::*;
  initial begin
    host_addr_lines = UPP_A_DATA;
    host_data_drv = 8'h00;
    host_select_n = 1'b1;
    host_read_n = 1'b1;
    host_write_n = 1'b1;
  end
  // Request held from a falling edge to the falling edge after the answer edge; x if no answer
  task automatic acc(input logic sel, input logic wrt, input upp_addr_t a, input upp_byte_t d,
    output upp_byte_t q, output bit done);
    q = 8'hxx;
    done = 1'b0;
    @(negedge sys_clk);
    host_addr_lines = a;
    host_data_drv = wrt ? d : ~host_data_drv;
    host_select_n = !sel;
    host_read_n = wrt;
    host_write_n = !wrt;
    for (int n = 0; n < 4; n++) begin
      @(posedge sys_clk);
      if (wrt || host_data_oe) begin
        q = host_data_out;
        done = 1'b1;
        break;
      end
    end
    @(negedge sys_clk);
    host_select_n = 1'b1;
    host_read_n = 1'b1;
    host_write_n = 1'b1;
    // Undriven bus has no pull, so show a changed value
    host_data_drv = ~host_data_drv;
  endtask
endmodule // upp_host_model

// ===== testbench/upp_host_port_assertions.sv
// Bus timing checks for the parallel host port
module upp_host_port_assertions (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire upp_pkg::upp_addr_t host_addr_lines,
  input wire upp_pkg::upp_byte_t host_data_in,
  input wire logic host_data_oe,
  input wire logic host_select_n,
  input wire logic host_read_n,
  input wire logic host_write_n,
  input wire logic bus_driver_disable,
  input wire logic host_irq,
  input wire logic tx_byte_valid,
  input wire upp_pkg::upp_byte_t line_control,
  input wire upp_pkg::upp_byte_t modem_control,
  input wire logic [15:0] baud_divisor
);
  import upp_pkg::*;
  wire logic sel_rd = !host_select_n && !host_read_n;
  wire logic sel_wr = !host_select_n && !host_write_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd; !sel_rd ##1 sel_rd; endsequence
  sequence s_wr(upp_addr_t a); !sel_wr ##1 sel_wr && host_addr_lines == a; endsequence
  a_read_drive: assert property (s_rd |=> host_data_oe && !bus_driver_disable)
    else $error("read not driven");
  a_read_release: assert property ($fell(sel_rd) |=> !host_data_oe && bus_driver_disable)
    else $error("bus not released");
  a_disable_cause: assert property (!bus_driver_disable |-> $past(sel_rd))
    else $error("disable without read");
  a_deselect_quiet: assert property (host_select_n |=> !host_data_oe)
    else $error("drive while deselected");
  a_irq_gated: assert property (!modem_control[UPP_MCR_AUX_OUT_B] [*2] |-> !host_irq)
    else $error("irq not gated");
  a_thr_pulse: assert property (s_wr(UPP_A_DATA) ##0 !line_control[7]
    |=> tx_byte_valid ##1 !tx_byte_valid) else $error("no tx pulse");
  a_div_load: assert property (s_wr(UPP_A_DIV_LO) ##0 line_control[7]
    |=> baud_divisor[7:0] == $past(host_data_in)) else $error("divisor not loaded");
  a_lcr_load: assert property (s_wr(UPP_A_LCR) |=> line_control == $past(host_data_in))
    else $error("lcr not loaded");
endmodule // upp_host_port_assertions
bind upp_host_port upp_host_port_assertions upp_host_port_assertions_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .host_addr_lines(host_addr_lines),
  .host_data_in(host_data_in), .host_data_oe(host_data_oe), .host_select_n(host_select_n),
  .host_read_n(host_read_n), .host_write_n(host_write_n),
  .bus_driver_disable(bus_driver_disable), .host_irq(host_irq),
  .tx_byte_valid(tx_byte_valid), .line_control(line_control),
  .modem_control(modem_control), .baud_divisor(baud_divisor));
